// ### pkg/sync_serial_pkg.sv
package sync_serial_pkg;

  // Register word offsets on the APB bus (byte addresses).
  localparam logic [7:0] OFS_BAUD_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RECEIVE_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BAUD_DIVISOR_LOW = 8'h08;
  localparam logic [7:0] OFS_BAUD_DIVISOR_HIGH = 8'h0c;
  localparam logic [7:0] OFS_TRANSMIT_HOLDING = 8'h10;
  localparam logic [7:0] OFS_TRANSMIT_CONTROL = 8'h14;
  localparam logic [7:0] OFS_RECEIVE_DATA = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;

  // Baud control fields.
  localparam int BC_DATA_INVERT = 5;
  localparam int BC_CLOCK_IDLE = 4;
  localparam int BC_WIDE_DIVISOR = 3;
  localparam int BC_WAKE_ON_BREAK = 1;
  localparam int BC_AUTO_BAUD_ARM = 0;
  // Receive status/control fields.
  localparam int RS_PORT_ENABLE = 7;
  localparam int RS_SINGLE_RX = 5;
  localparam int RS_CONT_RX = 4;
  localparam int RS_FRAMING_ERR = 2;
  // Transmit control fields.
  localparam int TC_CLOCK_SOURCE = 7;
  localparam int TC_NINE_BIT = 6;
  localparam int TC_TX_ENABLE = 5;
  localparam int TC_SYNC_MODE = 4;
  localparam int TC_HIGH_SPEED = 2;
  localparam int TC_SHIFT_EMPTY = 1;
  localparam int TC_NINTH_BIT = 0;
  // Flag register fields.
  localparam int FL_RX_COMPLETE = 1;
  localparam int FL_TX_BUF_EMPTY = 0;

  localparam logic [7:0] RST_BAUD_CONTROL = 8'h00;
  localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_CONTROL = 8'h02;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BREAK_DATA = 8'h00;
  localparam int DATA_BITS = 8;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic clkOut;
    logic clkOe;
    logic dataOut;
    logic dataOe;
  } pin_drive_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_RX = 3'b100
  } shift_state_t;

endpackage

// ### verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import sync_serial_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### verilog/baud_tick.sv
`timescale 1ns/1ps
`default_nettype none
module baud_tick
  import sync_serial_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic run,
  input wire logic wide,
  input wire logic highSpeed,
  input wire logic [15:0] divisor,
  output logic tick
);
  logic [15:0] count;
  logic [15:0] reload;
  logic [1:0] pre;
  logic [1:0] preTop;

  // Narrow divisor uses only the low byte; the prescale adds a further /4 at low speed.
  assign reload = wide ? divisor : {8'h00, divisor[7:0]};
  assign preTop = highSpeed ? 2'd0 : 2'd3;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      pre <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      count <= reload;
      pre <= '0;
      tick <= 1'b0;
    end else if (pre != preTop) begin
      pre <= pre + 2'd1;
      tick <= 1'b0;
    end else begin
      pre <= '0;
      tick <= (count == 16'h0000);
      count <= (count == 16'h0000) ? reload : count - 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### verilog/sync_serial_host.sv
//
// Operation
// - Break shows as receive-complete set, framing error set, received byte zero.
// - Wake-on-break flags on first edge, then receives next byte, flags again.
// - Clocked characters carry only data bits, no start or stop bits.
// - One two-way data line and one clock line, half-duplex only.
// - Sync select, clock-source host select and port enable configure the unit.
// - Both receive enables clear means transmit; either set means receive.
// - Host drives the clock pin, enabling its driver in sync transmit or receive.
// - Exactly one clock cycle per data bit, no extra cycles.
// - Data changes on leading edge, stable through trailing edge.
// - Polarity set: clock idles high, data changes falling, sampled rising.
// - Polarity clear: clock idles low, data changes rising, sampled falling.
// - Host transmit sends on data pin with data and clock drivers enabled.
// - Holding write starts send; waits while the shift register is busy.
// - Empty shift register loads from holding at once and shifts immediately.
// - The shift register has no register address.
// - Data invert resets to zero; when set, both directions invert.
// - Nine-bit mode sends the ninth-bit value after the eight holding bits.
// - Wake-on-break enable clears on the rising receive edge ending the break.
// - Transmit-buffer-empty flag rises when the holding register empties.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_host
  import sync_serial_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dataIn,
  input wire logic clkIn,
  output logic dataOut,
  output logic dataOe,
  output logic clkOut,
  output logic clkOe
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] baudControl;
  logic [7:0] rxStatusControl;
  logic [7:0] divisorLow;
  logic [7:0] divisorHigh;
  logic [7:0] txControl;
  logic [7:0] holdData;
  logic holdNinth;
  logic holdFull;
  logic [7:0] rxData;
  logic rxComplete;
  logic framingError;
  logic [8:0] shiftReg;
  logic [3:0] bitsLeft;
  logic phase;
  logic busy;
  shift_state_t state;
  logic [1:0] pinsSync;
  logic rxLevel;
  logic rxLevelPrev;
  logic wakeSeen;
  logic tick;
  pin_drive_t drive;

  logic wrEn;
  logic rdEn;
  logic hostSync;
  logic txMode;
  logic idleLevel;
  logic invert;
  logic rxPin;
  logic holdWrite;
  logic loadShift;
  logic lastBit;
  logic rxRead;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign invert = baudControl[BC_DATA_INVERT];
  assign idleLevel = baudControl[BC_CLOCK_IDLE];
  // Host synchronous operation needs sync, host clock source and port enable.
  assign hostSync = txControl[TC_SYNC_MODE] && txControl[TC_CLOCK_SOURCE]
                    && rxStatusControl[RS_PORT_ENABLE];
  assign txMode = !rxStatusControl[RS_SINGLE_RX] && !rxStatusControl[RS_CONT_RX];
  assign rxPin = pinsSync[0] ^ invert;
  assign holdWrite = wrEn && paddr == OFS_TRANSMIT_HOLDING;
  assign rxRead = rdEn && paddr == OFS_RECEIVE_DATA;
  assign lastBit = busy && tick && phase && bitsLeft == 4'd1;
  // Loads when the shift register is empty or frees on this very tick.
  assign loadShift = holdFull && hostSync && txMode && txControl[TC_TX_ENABLE]
                     && (state == TX_IDLE || (state == TX_SHIFT && lastBit));

  // ----------------------------------------------------------------
  // Pin synchronisers and baud generator
  // ----------------------------------------------------------------
  pin_sync #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async({clkIn, dataIn}),
    .synced(pinsSync)
  );

  baud_tick u_baud (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(busy),
    .wide(baudControl[BC_WIDE_DIVISOR]),
    .highSpeed(txControl[TC_HIGH_SPEED]),
    .divisor({divisorHigh, divisorLow}),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      baudControl <= RST_BAUD_CONTROL;
      divisorLow <= RST_BYTE;
      divisorHigh <= RST_BYTE;
    end else begin
      if (wrEn && paddr == OFS_BAUD_DIVISOR_LOW) begin
        divisorLow <= pwdata[7:0];
      end
      if (wrEn && paddr == OFS_BAUD_DIVISOR_HIGH) begin
        divisorHigh <= pwdata[7:0];
      end
      if (wrEn && paddr == OFS_BAUD_CONTROL) begin
        baudControl <= {2'b00, pwdata[5:3], 1'b0, pwdata[1:0]};
      end else if (baudControl[BC_WAKE_ON_BREAK] && rxLevel && !rxLevelPrev && wakeSeen) begin
        baudControl[BC_WAKE_ON_BREAK] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxStatusControl <= RST_RECEIVE_STATUS_CONTROL;
    end else if (wrEn && paddr == OFS_RECEIVE_STATUS_CONTROL) begin
      rxStatusControl <= {pwdata[7:4], 4'h0};
    end else if (state == TX_RX && lastBit && !rxStatusControl[RS_CONT_RX]) begin
      rxStatusControl[RS_SINGLE_RX] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txControl <= RST_TRANSMIT_CONTROL;
    end else if (wrEn && paddr == OFS_TRANSMIT_CONTROL) begin
      txControl <= {pwdata[7:4], 1'b0, pwdata[2], 1'b0, pwdata[0]};
    end
  end

  // ----------------------------------------------------------------
  // Holding register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      holdData <= RST_BYTE;
      holdNinth <= 1'b0;
      holdFull <= 1'b0;
    end else if (holdWrite) begin
      holdData <= pwdata[7:0];
      holdNinth <= txControl[TC_NINTH_BIT];
      holdFull <= 1'b1;
    end else if (loadShift) begin
      holdFull <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine: the shift register is internal only.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= TX_IDLE;
      shiftReg <= '0;
      bitsLeft <= '0;
      phase <= 1'b0;
      busy <= 1'b0;
    end else begin
      case (state)
        TX_IDLE: begin
          phase <= 1'b0;
          if (loadShift) begin
            // Data bits only, no framing bits.
            shiftReg <= {holdNinth, holdData};
            bitsLeft <= txControl[TC_NINE_BIT] ? 4'd9 : 4'd8;
            busy <= 1'b1;
            state <= TX_SHIFT;
          end else if (hostSync && !txMode) begin
            bitsLeft <= 4'(DATA_BITS);
            busy <= 1'b1;
            state <= TX_RX;
          end
        end
        TX_SHIFT, TX_RX: begin
          if (state == TX_RX && txMode) begin
            // Dropping both receive enables stops the clock mid-character.
            busy <= 1'b0;
            state <= TX_IDLE;
          end else if (tick) begin
            phase <= !phase;
            if (phase) begin
              // Trailing half ends a bit; the next leading edge presents new data.
              if (state == TX_RX) begin
                shiftReg <= {1'b0, rxPin, shiftReg[7:1]};
              end else begin
                shiftReg <= {1'b0, shiftReg[8:1]};
              end
              bitsLeft <= bitsLeft - 4'd1;
              if (loadShift) begin
                shiftReg <= {holdNinth, holdData};
                bitsLeft <= txControl[TC_NINE_BIT] ? 4'd9 : 4'd8;
              end else if (bitsLeft == 4'd1) begin
                busy <= 1'b0;
                state <= TX_IDLE;
              end
            end
          end
        end
        default: begin
          busy <= 1'b0;
          state <= TX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive flags, break and wake-on-break
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxLevel <= 1'b1;
      rxLevelPrev <= 1'b1;
      wakeSeen <= 1'b0;
    end else begin
      rxLevel <= rxPin;
      rxLevelPrev <= rxLevel;
      if (!baudControl[BC_WAKE_ON_BREAK]) begin
        wakeSeen <= 1'b0;
      end else if (!rxLevel && rxLevelPrev) begin
        wakeSeen <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxData <= RST_BYTE;
      rxComplete <= 1'b0;
      framingError <= 1'b0;
    end else begin
      if (state == TX_RX && lastBit) begin
        rxData <= {rxPin, shiftReg[7:1]};
        // An all-zero byte in clocked mode is reported like a break.
        framingError <= ({rxPin, shiftReg[7:1]} == BREAK_DATA);
        rxComplete <= 1'b1;
      end else if (baudControl[BC_WAKE_ON_BREAK] && !rxLevel && rxLevelPrev && !wakeSeen) begin
        rxComplete <= 1'b1;
      end else if (rxRead) begin
        rxComplete <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, every output from a flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      drive <= '0;
    end else begin
      // Clock driver on in any host sync mode; rests at idle level.
      drive.clkOe <= hostSync;
      drive.clkOut <= busy ? (idleLevel ^ !phase ^ 1'b1) : idleLevel;
      // Data driver only while transmitting, never while receiving.
      drive.dataOe <= hostSync && txMode;
      // A new bit appears only as the clock leaves idle, so the trailing edge sees
      // settled data; between characters the line keeps its last bit.
      if (busy && phase && drive.clkOut == idleLevel) begin
        drive.dataOut <= shiftReg[0] ^ invert;
      end
    end
  end

  assign clkOut = drive.clkOut;
  assign clkOe = drive.clkOe;
  assign dataOut = drive.dataOut;
  assign dataOe = drive.dataOe;

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFS_BAUD_CONTROL: prdata <= {24'h0, baudControl};
          OFS_RECEIVE_STATUS_CONTROL: prdata <= {24'h0, rxStatusControl[7:3], framingError, 2'b00};
          OFS_BAUD_DIVISOR_LOW: prdata <= {24'h0, divisorLow};
          OFS_BAUD_DIVISOR_HIGH: prdata <= {24'h0, divisorHigh};
          OFS_TRANSMIT_HOLDING: prdata <= {24'h0, holdData};
          OFS_TRANSMIT_CONTROL: prdata <= {24'h0, txControl[7:2], !busy, txControl[0]};
          OFS_RECEIVE_DATA: prdata <= {24'h0, rxData};
          OFS_FLAGS: prdata <= {30'h0, rxComplete, !holdFull};
          default: pslverr <= 1'b0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### tb/sync_serial_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sync_serial_host_assertions
  import sync_serial_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dataIn,
  input wire logic clkIn,
  input wire logic dataOut,
  input wire logic dataOe,
  input wire logic clkOut,
  input wire logic clkOe
);
  wire logic wrDone = psel && penable && pready && pwrite;
  wire logic rdDone = psel && penable && pready && !pwrite;
  logic idleHigh;
  // The idle level is tracked so that a trailing edge can be told from a leading one.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idleHigh <= 1'b0;
    end else if (wrDone && paddr == OFS_BAUD_CONTROL) begin
      idleHigh <= pwdata[BC_CLOCK_IDLE];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_ready_first: assert property ($rose(penable) && psel |-> pready)
    else $error("no ready in first access cycle");
  a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside one access cycle");
  a_unmapped_zero: assert property (rdDone && paddr > OFS_FLAGS |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_clock_driven: assert property ($changed(clkOut) |-> clkOe || $past(clkOe))
    else $error("clock moved without its driver");
  a_data_with_clock: assert property (dataOe |-> clkOe)
    else $error("data driven without clock driver");
  a_data_at_trailing: assert property (
    $changed(clkOut) && clkOut == idleHigh && dataOe |-> $stable(dataOut))
    else $error("data moved at trailing edge");
  a_idle_follows: assert property ($changed(idleHigh) |-> ##[1:4] clkOut == idleHigh)
    else $error("clock not at idle level");
  a_rx_releases: assert property (
    wrDone && paddr == OFS_RECEIVE_STATUS_CONTROL && (pwdata[RS_SINGLE_RX] || pwdata[RS_CONT_RX])
    |-> ##[1:3] !dataOe)
    else $error("data driver kept in receive mode");
endmodule
bind sync_serial_host sync_serial_host_assertions sync_serial_host_assertions_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dataIn(dataIn), .clkIn(clkIn), .dataOut(dataOut), .dataOe(dataOe), .clkOut(clkOut),
  .clkOe(clkOe)
);
`default_nettype wire

// ### tb/sync_client_model.sv
`timescale 1ns/1ps
`default_nettype none
module sync_client_model (
  input wire logic clkPin,
  input wire logic dataPin,
  input wire logic idleHigh,
  input wire logic respond,
  input wire logic holdLow,
  input wire logic [7:0] sendByte,
  output logic lineOut,
  output logic lineOe,
  output logic [15:0] seen,
  output int bitCount
);
  logic [7:0] pend;
  logic bitVal;
  // Drives only while told the host receives or told to hold the line low; respond held past a single receive overlaps the host's data driver.
  assign lineOe = respond || holdLow;
  assign lineOut = holdLow ? 1'b0 : bitVal;
  initial begin
    seen = 16'h0;
    bitCount = 0;
    bitVal = 1'b1;
    pend = 8'h0;
  end
  always @(posedge respond) begin
    pend = sendByte;
  end
  always @(clkPin) begin
    if (clkPin == idleHigh) begin
      seen = {dataPin, seen[15:1]};
      bitCount++;
    end else if (respond) begin
      bitVal = pend[0];
      pend = pend >> 1;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_sync_serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sync_serial_host
  import sync_serial_pkg::*;
;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
  logic dataOut, dataOe, clkOut, clkOe, mOut, mOe, respond, holdLow, idleHigh;
  logic dataLast, clkLast;
  logic [7:0] paddr, sendByte;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] seen;
  int bitCount, base, errCount, totalChecks, cycles;
  // A released line shows the inverse of its last level, never a convenient constant.
  wire logic dataLine = dataOe ? dataOut : (mOe ? mOut : ~dataLast);
  wire logic clkLine = clkOe ? clkOut : ~clkLast;
  sync_serial_host sync_serial_host_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dataIn(dataLine), .clkIn(clkLine), .dataOut(dataOut), .dataOe(dataOe),
    .clkOut(clkOut), .clkOe(clkOe)
  );
  sync_client_model sync_client_model_i (
    .clkPin(clkLine), .dataPin(dataLine), .idleHigh(idleHigh), .respond(respond),
    .holdLow(holdLow), .sendByte(sendByte), .lineOut(mOut), .lineOe(mOe), .seen(seen),
    .bitCount(bitCount)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    dataLast <= (dataOe || mOe) ? dataLine : dataLast;
    clkLast <= clkOe ? clkOut : clkLast;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errCount++;
      closeOut();
    end
  end
  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) chk("ready", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, q & m);
  endtask
  // The idle wait after the last bit is what exposes a spare clock cycle.
  task automatic bits(input int n);
    int k;
    k = 0;
    while (bitCount < base + n && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (60) @(posedge clk_sys);
    chk("clock count", base + n, bitCount);
  endtask
  task automatic rxWait();
    int k;
    k = 0;
    q = 32'h0;
    while (q[FL_RX_COMPLETE] !== 1'b1 && k < 100) begin
      apb(1'b0, OFS_FLAGS, 32'h0);
      k++;
    end
    chk("rx flag", 32'h1, {31'h0, q[FL_RX_COMPLETE]});
  endtask
  initial begin
    {psel, penable, pwrite, respond, holdLow, idleHigh, arst_n, clkLast} = '0;
    {paddr, pwdata, sendByte} = '0;
    dataLast = 1'b1;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd("baud ctl", OFS_BAUD_CONTROL, 32'hff, {24'h0, RST_BAUD_CONTROL});
    rd("rx ctl", OFS_RECEIVE_STATUS_CONTROL, 32'hff, {24'h0, RST_RECEIVE_STATUS_CONTROL});
    rd("tx ctl", OFS_TRANSMIT_CONTROL, 32'hff, {24'h0, RST_TRANSMIT_CONTROL});
    rd("flags", OFS_FLAGS, 32'hff, 32'h1);
    wr(8'h20, 32'hff);
    rd("unmapped", 8'h20, 32'hffffffff, 32'h0);
    chk("slverr", 32'h0, {31'h0, pslverr});
    wr(OFS_BAUD_DIVISOR_LOW, 32'h9);
    wr(OFS_TRANSMIT_CONTROL, 32'h94);
    wr(OFS_RECEIVE_STATUS_CONTROL, 32'h80);
    wr(OFS_TRANSMIT_CONTROL, 32'hb4);
    repeat (4) @(posedge clk_sys);
    chk("pins", 32'h6, {29'h0, clkOe, dataOe, clkOut});
    base = bitCount;
    wr(OFS_TRANSMIT_HOLDING, 32'ha5);
    wr(OFS_TRANSMIT_HOLDING, 32'h3c);
    rd("holding full", OFS_FLAGS, 32'h1, 32'h0);
    bits(16);
    chk("two chars", 32'h3ca5, {16'h0, seen});
    rd("holding empty", OFS_FLAGS, 32'h1, 32'h1);
    wr(OFS_TRANSMIT_CONTROL, 32'hf5);
    base = bitCount;
    wr(OFS_TRANSMIT_HOLDING, 32'h5a);
    bits(9);
    chk("nine bits", 32'h15a, {23'h0, seen[15:7]});
    wr(OFS_TRANSMIT_CONTROL, 32'hb4);
    wr(OFS_BAUD_CONTROL, 32'h10);
    repeat (4) @(posedge clk_sys);
    idleHigh <= 1'b1;
    chk("idle high", 32'h1, {31'h0, clkOut});
    wr(OFS_BAUD_CONTROL, 32'h30);
    base = bitCount;
    wr(OFS_TRANSMIT_HOLDING, 32'h0f);
    bits(8);
    chk("inverted", 32'hf0, {24'h0, seen[15:8]});
    wr(OFS_BAUD_CONTROL, 32'h10);
    wr(OFS_BAUD_CONTROL, 32'h00);
    idleHigh <= 1'b0;
    sendByte <= 8'h96;
    wr(OFS_RECEIVE_STATUS_CONTROL, 32'ha0);
    repeat (3) @(posedge clk_sys);
    chk("released", 32'h0, {31'h0, dataOe});
    respond <= 1'b1;
    rxWait();
    rd("rx byte", OFS_RECEIVE_DATA, 32'hff, 32'h96);
    rd("no break", OFS_RECEIVE_STATUS_CONTROL, 32'h4, 32'h0);
    rd("flag clear", OFS_FLAGS, 32'h2, 32'h0);
    respond <= 1'b0;
    sendByte <= 8'h00;
    wr(OFS_RECEIVE_STATUS_CONTROL, 32'ha0);
    repeat (3) @(posedge clk_sys);
    respond <= 1'b1;
    rxWait();
    rd("break err", OFS_RECEIVE_STATUS_CONTROL, 32'h4, 32'h4);
    rd("break byte", OFS_RECEIVE_DATA, 32'hff, {24'h0, BREAK_DATA});
    respond <= 1'b0;
    wr(OFS_TRANSMIT_CONTROL, 32'h04);
    wr(OFS_RECEIVE_STATUS_CONTROL, 32'h80);
    holdLow <= 1'b1;
    repeat (2) @(posedge clk_sys);
    holdLow <= 1'b0;
    wr(OFS_BAUD_CONTROL, 32'h03);
    holdLow <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd("wake flag", OFS_FLAGS, 32'h2, 32'h2);
    rd("wake armed", OFS_BAUD_CONTROL, 32'h2, 32'h2);
    holdLow <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd("wake done", OFS_BAUD_CONTROL, 32'h2, 32'h0);
    closeOut();
  end
endmodule
`default_nettype wire
